/* design/pgs_consts.svh */
// Constants for the pin output set block: offsets, field positions, resets.
// Assumes inclusion by the package and the top module only.
`ifndef PGS_CONSTS_SVH
`define PGS_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define PGS_OFF_OUTPUT_SET 8'h00
`define PGS_OFF_FUNC_SEL 8'h04
`define PGS_OFF_DIR 8'h08
`define PGS_OFF_LATCH 8'h0C
`define PGS_OFF_IMPL 8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PGS_BIT_SLAVE_OUT 11
`define PGS_BIT_SLAVE_IN 10
`define PGS_BIT_SERIAL_CLOCK 9
`define PGS_BIT_ENABLE 8
`define PGS_CS_MSB 7
`define PGS_PIN_COUNT 12

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PGS_RST_PINS 12'h000
`define PGS_RST_WORD 32'h0000_0000
`define PGS_RST_CS_IMPL 8'hFF

`endif

/* design/pgs_pkg.sv */
// Types for the pin output set block.
// Assumes pgs_consts.svh sits beside it.
`include "pgs_consts.svh"

package pgs_pkg;
    typedef logic [`PGS_PIN_COUNT-1:0] pgs_pins_t;
    typedef logic [7:0] pgs_addr_t;
    typedef logic [31:0] pgs_word_t;
endpackage

/* design/pgs_pin_bit.sv */
// One pin slice: output latch with set and clear, pad drive and enable.
// Assumes synchronous inputs on i_clock.
`timescale 1ns/10ps

module pgs_pin_bit (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // Control
    input wire logic i_set,
    input wire logic i_clear,
    input wire logic i_gpio_mode,
    input wire logic i_dir_out,
    // Pad
    output logic o_latch,
    output logic o_pin_out,
    output logic o_pin_oe
);
    logic next_latch;

    // Set wins when both arrive in the same cycle
    always_comb begin
        next_latch = o_latch;
        if (i_clear) begin
            next_latch = 1'b0;
        end
        if (i_set) begin
            next_latch = 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_latch <= 1'b0;
        end else begin
            o_latch <= next_latch;
        end
    end

    // Pad registered so the top sees flip-flop outputs only
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_pin_out <= 1'b0;
            o_pin_oe <= 1'b0;
        end else begin
            o_pin_out <= next_latch & i_gpio_mode & i_dir_out;
            o_pin_oe <= i_gpio_mode & i_dir_out;
        end
    end
endmodule

/* design/pgs_output_set.sv */
// Pin output set register for the serial port pins used as general I/O.
// Assumes a simple strobe register port, synchronous pins, one clock.
//
// Functional notes
// - Bits 31-12 read zero, writes ignored
// - Bit 11 one sets slave-out latch
// - Bit 10 one sets slave-in latch
// - Bit 9 one sets serial clock latch
// - Bit 8 one sets enable latch
// - Bits 7-0 one set chip-select latches
// - Reads return live pin levels
// - Pin driven only when general-purpose output
// - Reset clears all latches to zero; upper bits read-only
// - Latch drives pin in general-purpose output mode
`timescale 1ns/10ps
`include "pgs_consts.svh"

module pgs_output_set #(
    parameter logic [7:0] CS_IMPL = `PGS_RST_CS_IMPL
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // Register port
    input wire pgs_pkg::pgs_addr_t i_addr,
    input wire pgs_pkg::pgs_word_t i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output pgs_pkg::pgs_word_t o_rdata,
    // Pins: slave-out 11, slave-in 10, clock 9, enable 8, chip-selects 7-0
    input wire pgs_pkg::pgs_pins_t i_pin,
    output pgs_pkg::pgs_pins_t o_pin,
    output pgs_pkg::pgs_pins_t o_pin_oe,
    // Latch state for the neighbouring clear logic
    input wire pgs_pkg::pgs_pins_t i_latch_clear,
    output pgs_pkg::pgs_pins_t o_latch
);
    import pgs_pkg::*;

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    pgs_pins_t func_sel;
    pgs_pins_t dir_out;
    pgs_pins_t latch;
    pgs_pins_t set_mask;
    pgs_pins_t pin_mask;
    logic wr_set;

    assign pin_mask = {4'hF, CS_IMPL};
    assign wr_set = i_wr && (i_addr == `PGS_OFF_OUTPUT_SET);
    // Only low bits matter; upper write data is dropped
    assign set_mask = wr_set ? (i_wdata[`PGS_PIN_COUNT-1:0] & pin_mask)
                             : `PGS_RST_PINS;

    // Function select: 1 means general-purpose, 0 means serial function
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            func_sel <= `PGS_RST_PINS;
        end else if (i_wr && i_addr == `PGS_OFF_FUNC_SEL) begin
            func_sel <= i_wdata[`PGS_PIN_COUNT-1:0] & pin_mask;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            dir_out <= `PGS_RST_PINS;
        end else if (i_wr && i_addr == `PGS_OFF_DIR) begin
            dir_out <= i_wdata[`PGS_PIN_COUNT-1:0] & pin_mask;
        end
    end

    // ----------------------------------------------------------------
    // Per-pin latches
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `PGS_PIN_COUNT; g++) begin : g_pin
            pgs_pin_bit u_bit (
                .i_clock(i_clock),
                .i_sys_rst(i_sys_rst),
                .i_set(set_mask[g]),
                .i_clear(i_latch_clear[g]),
                .i_gpio_mode(func_sel[g]),
                .i_dir_out(dir_out[g]),
                .o_latch(latch[g]),
                .o_pin_out(o_pin[g]),
                .o_pin_oe(o_pin_oe[g])
            );
        end
    endgenerate

    // Latch flip-flops face the neighbour directly, no extra lag behind the pads
    assign o_latch = latch;

    // ----------------------------------------------------------------
    // Read path, data one cycle after the strobe
    // ----------------------------------------------------------------
    pgs_word_t next_rdata;

    always_comb begin
        next_rdata = `PGS_RST_WORD;
        if (i_rd) begin
            unique case (i_addr)
                `PGS_OFF_OUTPUT_SET: begin
                    next_rdata[`PGS_PIN_COUNT-1:0] = i_pin & pin_mask;
                end
                `PGS_OFF_FUNC_SEL: begin
                    next_rdata[`PGS_PIN_COUNT-1:0] = func_sel;
                end
                `PGS_OFF_DIR: begin
                    next_rdata[`PGS_PIN_COUNT-1:0] = dir_out;
                end
                `PGS_OFF_LATCH: begin
                    next_rdata[`PGS_PIN_COUNT-1:0] = latch;
                end
                `PGS_OFF_IMPL: begin
                    next_rdata[`PGS_PIN_COUNT-1:0] = pin_mask;
                end
                default: begin
                    next_rdata = `PGS_RST_WORD;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_rdata <= `PGS_RST_WORD;
        end else begin
            o_rdata <= next_rdata;
        end
    end
endmodule

/* verification/pgs_output_set_assertions.sv */
// Checker for the pin output set block; sees the top module's ports only.
// Assumes a bind from the testbench top file and one clock domain.
`timescale 1ns/10ps
module pgs_output_set_assertions (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // Register port
    input wire pgs_pkg::pgs_addr_t i_addr,
    input wire pgs_pkg::pgs_word_t i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire pgs_pkg::pgs_word_t o_rdata,
    // Pins and latch
    input wire pgs_pkg::pgs_pins_t i_pin,
    input wire pgs_pkg::pgs_pins_t o_pin,
    input wire pgs_pkg::pgs_pins_t o_pin_oe,
    input wire pgs_pkg::pgs_pins_t i_latch_clear,
    input wire pgs_pkg::pgs_pins_t o_latch
);
    import pgs_pkg::*;
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    logic sw;
    pgs_pins_t wd, lq, pq;
    assign sw = i_wr && i_addr == 8'h00;
    // Last-cycle copies, cheaper than many past calls
    always_ff @(posedge i_clock) begin
        wd <= i_wdata[11:0];
        lq <= o_latch;
        pq <= i_pin;
    end
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    set_bits_a: assert property (sw |=> (o_latch & wd) == wd)
        else $error("set bit lost");
    zero_keep_a: assert property (sw && i_latch_clear == 12'h000 |=>
        (o_latch & ~wd) == (lq & ~wd)) else $error("zero bit changed latch");
    live_read_a: assert property (i_rd && i_addr == 8'h00 |=> o_rdata == {20'h0, pq})
        else $error("read not live pins");
    upper_zero_a: assert property (o_rdata[31:12] == 20'h0)
        else $error("upper bits not zero");
    unmapped_read_a: assert property (i_rd && i_addr > 8'h10 |=> o_rdata == 32'h0)
        else $error("unmapped read not zero");
    gated_pin_a: assert property ((o_pin & ~o_pin_oe) == 12'h000)
        else $error("pin driven while disabled");
    pin_follow_a: assert property (((o_pin ^ o_latch) & o_pin_oe) == 12'h000)
        else $error("pin differs from latch");
    reset_zero_a: assert property ($fell(i_sys_rst) |-> o_latch == 12'h000 && o_pin_oe == 12'h000)
        else $error("not clear after reset");
    cover property (sw);
    cover property (i_rd && i_addr == 8'h00);
    cover property (o_pin_oe != 12'h000);
endmodule

/* verification/testbench.sv */
// Self-checking bench for the pin output set block.
// Assumes the design package and the checker are compiled first.
`timescale 1ns/10ps
module testbench;
    import pgs_pkg::*;
    logic i_clock = 1'b0, i_sys_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, rd_d = 1'b0;
    pgs_addr_t i_addr = 8'h00;
    pgs_word_t i_wdata = 32'h0, o_rdata, p, w;
    pgs_pins_t i_pin = 12'h000, i_latch_clear = 12'h000, o_pin, o_pin_oe, o_latch, acc = 12'h000;
    pgs_word_t exp_q[$];
    int miscompares = 0, check_count = 0, seed = 32'h94D63F79;
    always #5 i_clock = ~i_clock;
    pgs_output_set dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin(i_pin),
        .o_pin(o_pin), .o_pin_oe(o_pin_oe), .i_latch_clear(i_latch_clear), .o_latch(o_latch));
    task automatic chk(input pgs_word_t got, input pgs_word_t e);
        check_count++;
        if (got !== e) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask
    task automatic final_report;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr(input pgs_addr_t a, input pgs_word_t d);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
        @(posedge i_clock);
    endtask
    // Read data stand only in the next cycle; the monitor pops then
    task automatic rd(input pgs_addr_t a, input pgs_pins_t pin, input pgs_word_t e);
        i_rd <= 1'b1;
        i_addr <= a;
        i_pin <= pin;
        exp_q.push_back(e);
        @(posedge i_clock);
        i_rd <= 1'b0;
        @(posedge i_clock);
    endtask
    always @(posedge i_clock) rd_d <= i_rd;
    always @(negedge i_clock) if (rd_d) chk(o_rdata, exp_q.pop_front());
    initial begin
        #20000;
        miscompares++;
        final_report();
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        @(posedge i_clock);
        rd(8'h0C, 12'h000, 32'h0);
        wr(8'h04, 32'h0000_0FFF);
        wr(8'h08, 32'h0000_0FFF);
        for (int k = 0; k < 8; k++) begin
            p = $random(seed);
            rd(8'h00, p[11:0], {20'h0, p[11:0]});
            w = $random(seed) & $random(seed);
            acc |= w[11:0];
            wr(8'h00, w);
            @(negedge i_clock);
            chk({20'h0, o_latch}, {20'h0, acc});
            chk({20'h0, o_pin}, {20'h0, acc});
            @(posedge i_clock);
        end
        rd(8'h0C, 12'h000, {20'h0, acc});
        // Set and clear in one cycle: set must win on bit 0
        i_latch_clear <= 12'hFFF;
        i_wr <= 1'b1;
        i_addr <= 8'h00;
        i_wdata <= 32'h0000_0001;
        @(posedge i_clock);
        i_wr <= 1'b0;
        i_latch_clear <= 12'h000;
        @(negedge i_clock);
        chk({20'h0, o_latch}, 32'h0000_0001);
        @(posedge i_clock);
        rd(8'h0C, 12'h000, 32'h0000_0001);
        wr(8'h04, 32'h0);
        @(negedge i_clock);
        chk({20'h0, o_pin_oe}, 32'h0);
        @(posedge i_clock);
        rd(8'h1C, 12'hFFF, 32'h0);
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        @(posedge i_clock);
        rd(8'h0C, 12'h000, 32'h0);
        final_report();
    end
endmodule
bind pgs_output_set pgs_output_set_assertions chk_i (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_pin(i_pin), .o_pin(o_pin), .o_pin_oe(o_pin_oe), .i_latch_clear(i_latch_clear),
    .o_latch(o_latch));
